// *** hw/lane_pkg.sv ***
// constants shared by the serdes lane: register map, field layout, reset values, counts
// assumes one system clock samples every lane clock; registers sit behind an avalon-mm slave
package lane_pkg;

    // ************************************************
    // widths
    // ************************************************
    localparam int unsigned MAX_WORD_W = 10;
    localparam int unsigned FACTOR_W   = 4;
    localparam int unsigned TAP_W      = 6;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned DATA_W     = 32;

    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [ADDR_W-1:0] CTRL_OFFS = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_OFFS = 4'h4;

    // ************************************************
    // control fields
    // ************************************************
    localparam int unsigned CTRL_FACTOR_LSB = 0;
    localparam int unsigned CTRL_HALF_BIT   = 4;
    localparam int unsigned CTRL_FIFO_BIT   = 5;
    localparam int unsigned CTRL_MODE_LSB   = 6;
    localparam int unsigned CTRL_DTERM_BIT  = 8;
    localparam int unsigned CTRL_STERM_BIT  = 9;
    localparam int unsigned CTRL_USED_W     = 10;
    localparam logic [CTRL_USED_W-1:0] CTRL_RESET = 10'h018; // factor 8, half rate

    // ************************************************
    // status fields
    // ************************************************
    localparam int unsigned STAT_LOCK_BIT  = 0;
    localparam int unsigned STAT_EMPTY_BIT = 1;
    localparam int unsigned STAT_FINAL_LSB = 8;
    localparam int unsigned STAT_TAP_LSB   = 16;

    // ************************************************
    // counts and defaults
    // ************************************************
    localparam int unsigned FIFO_DEPTH_DEF = 4;
    localparam int unsigned LOCK_WORDS_DEF = 8;
    localparam logic [FACTOR_W-1:0] FACTOR_ONE = 4'h1;
    localparam logic [FACTOR_W-1:0] FACTOR_MAX = 4'ha;
    localparam logic [TAP_W-1:0]    TAP_ZERO   = 6'h00;
    localparam logic [TAP_W-1:0]    TAP_TOP    = 6'h3f;

    // delay mode encoding in the control register
    typedef enum logic [1:0] {
        DLY_STATIC  = 2'h0,
        DLY_DYNAMIC = 2'h1,
        DLY_ALIGN   = 2'h2
    } delay_mode_t;

endpackage

// *** hw/pin_sync.sv ***
// two-stage synchroniser with edge detect on the second stage
// assumes inputs come from outside the clk_sys domain
`timescale 1ns/1ps

module pin_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;
    logic [W-1:0] prev_q;

    // ************************************************
    // capture chain
    // ************************************************
    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q   <= '0;
            stable_q <= '0;
            prev_q   <= '0;
        end else if (ce) begin
            meta_q   <= pin;
            stable_q <= meta_q;
            prev_q   <= stable_q;
        end
    end

    // edges are seen in the same cycle the level changes
    assign level = stable_q;
    assign rise  = stable_q & ~prev_q;
    assign fall  = ~stable_q & prev_q;

endmodule

// *** hw/serdes_lane.sv ***
// bidirectional serdes lane: deserializer, serializer, read-side queue, delay control
// assumes every lane clock is a pin sampled by clk_sys, far slower than clk_sys
`timescale 1ns/1ps

// How it works
// - received words delivered as parallel data
// - core words serialized onto the pads
// - separate slow and fast clocks per direction
// - empty flag raised while queue holds nothing
// - words popped only on read strobe
// - receive reset clears queue and deserializer
// - buffer enable gates receive capture
// - termination follows control pin in dynamic mode
// - lock raised after training; data withheld before
// - delay enable starts stepping or training
// - step up or down in dynamic mode
// - delay reset clears counter or training
// - final tap shown once locked
// - transmit reset clears the serializer
// - output enable drives the pad pair
// - half rate uses both fast edges
// - words handed over on slow rising edge
module serdes_lane
    import lane_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = lane_pkg::FIFO_DEPTH_DEF,
    parameter int unsigned LOCK_WORDS = lane_pkg::LOCK_WORDS_DEF
) (
    input  wire logic                            clk_sys,
    input  wire logic                            rst,
    input  wire logic                            ce,
    // register bus
    input  wire logic [lane_pkg::ADDR_W-1:0]     avs_address,
    input  wire logic                            avs_read,
    input  wire logic                            avs_write,
    input  wire logic [lane_pkg::DATA_W-1:0]     avs_writedata,
    input  wire logic [3:0]                      avs_byteenable,
    output logic      [lane_pkg::DATA_W-1:0]     avs_readdata,
    output logic                                 avs_waitrequest,
    // lane clocks
    input  wire logic                            rx_parallel_clock,
    input  wire logic                            rx_serial_clock,
    input  wire logic                            tx_parallel_clock,
    input  wire logic                            tx_serial_clock,
    input  wire logic                            xfer_queue_read_clock,
    // receive side
    input  wire logic                            rx_path_reset,
    input  wire logic                            input_buffer_on,
    input  wire logic                            termination_ctrl,
    input  wire logic                            xfer_queue_read,
    output logic                                 xfer_queue_empty,
    output logic      [lane_pkg::MAX_WORD_W-1:0] rx_word,
    output logic                                 rx_word_valid,
    output logic                                 termination_on,
    // delay control
    input  wire logic                            delay_adjust_enable,
    input  wire logic                            delay_step_up,
    input  wire logic                            delay_adjust_reset,
    output logic                                 align_lock,
    output logic      [lane_pkg::TAP_W-1:0]      final_delay_setting,
    // transmit side
    input  wire logic [lane_pkg::MAX_WORD_W-1:0] tx_word,
    input  wire logic                            tx_path_reset,
    input  wire logic                            output_enable,
    // pads
    input  wire logic                            pad_p_i,
    input  wire logic                            pad_n_i,
    output logic                                 pad_p_o,
    output logic                                 pad_n_o,
    output logic                                 pad_oe
);

    import lane_pkg::*;

    localparam int unsigned PW     = $clog2(FIFO_DEPTH);
    localparam int unsigned SYNC_W = 16 + MAX_WORD_W;

    // ************
    // input synchronisers
    // ************
    logic [SYNC_W-1:0] s_lvl;
    logic [SYNC_W-1:0] s_rise;
    logic [SYNC_W-1:0] s_fall;

    // every lane clock and control pin shares one chain so edges stay aligned
    pin_sync #(.W(SYNC_W)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .pin     ({tx_word, pad_n_i, pad_p_i, output_enable, tx_path_reset, xfer_queue_read,
                   delay_adjust_reset, delay_step_up, delay_adjust_enable, termination_ctrl,
                   input_buffer_on, rx_path_reset, xfer_queue_read_clock, tx_serial_clock,
                   tx_parallel_clock, rx_serial_clock, rx_parallel_clock}),
        .level   (s_lvl),
        .rise    (s_rise),
        .fall    (s_fall)
    );

    logic rxp_rise;
    logic rxs_rise;
    logic rxs_fall;
    logic txp_rise;
    logic txs_rise;
    logic txs_fall;
    logic rdc_rise;
    logic rx_rst_s;
    logic buf_on_s;
    logic term_s;
    logic dly_en_s;
    logic dly_up_s;
    logic delay_adjust_reset_s;
    logic rd_s;
    logic tx_rst_s;
    logic oe_s;
    logic pad_bit_s;
    logic [MAX_WORD_W-1:0] tx_word_s;

    assign rxp_rise  = s_rise[0];
    assign rxs_rise  = s_rise[1];
    assign rxs_fall  = s_fall[1];
    assign txp_rise  = s_rise[2];
    assign txs_rise  = s_rise[3];
    assign txs_fall  = s_fall[3];
    assign rdc_rise  = s_rise[4];
    assign rx_rst_s  = s_lvl[5];
    assign buf_on_s  = s_lvl[6];
    assign term_s    = s_lvl[7];
    assign dly_en_s  = s_lvl[8];
    assign dly_up_s  = s_lvl[9];
    assign delay_adjust_reset_s = s_lvl[10];
    assign rd_s      = s_lvl[11];
    assign tx_rst_s  = s_lvl[12];
    assign oe_s      = s_lvl[13];
    assign pad_bit_s = s_lvl[14] & ~s_lvl[15];    // differential: p high, n low
    assign tx_word_s = s_lvl[SYNC_W-1:16];

    // ************
    // register slave
    // ************
    logic [CTRL_USED_W-1:0] ctrl_q;
    logic                   ack_q;
    logic                   hit_ctrl;
    logic                   hit_stat;
    logic [DATA_W-1:0]      stat_word;

    assign hit_ctrl        = (avs_address == CTRL_OFFS);
    assign hit_stat        = (avs_address == STAT_OFFS);
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    // one wait cycle per access, ack drops again so each request is taken once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else if (ce) begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // control register, byte lanes 0 and 1 hold the fields
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (ce && avs_write && ack_q && hit_ctrl) begin
            if (avs_byteenable[0]) begin
                ctrl_q[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                ctrl_q[CTRL_USED_W-1:8] <= avs_writedata[CTRL_USED_W-1:8];
            end
        end
    end

    // read data registered; unmapped offsets read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (ce && avs_read && !ack_q) begin
            if (hit_ctrl) begin
                avs_readdata <= {{(DATA_W-CTRL_USED_W){1'b0}}, ctrl_q};
            end else if (hit_stat) begin
                avs_readdata <= stat_word;
            end else begin
                avs_readdata <= '0;
            end
        end
    end

    // ************
    // configuration decode
    // ************
    logic [FACTOR_W-1:0] factor_raw;
    logic [FACTOR_W-1:0] factor;
    logic                half_rate;
    logic                fifo_on;
    delay_mode_t         dly_mode;

    assign factor_raw = ctrl_q[CTRL_FACTOR_LSB +: FACTOR_W];
    // one shared factor, so rx and tx cannot disagree
    assign factor     = (factor_raw == '0 || factor_raw > FACTOR_MAX) ? FACTOR_MAX : factor_raw;
    assign half_rate  = ctrl_q[CTRL_HALF_BIT];
    assign fifo_on    = ctrl_q[CTRL_FIFO_BIT];
    assign dly_mode   = delay_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
    // static mode takes the register bit, dynamic mode the pin
    assign termination_on = ctrl_q[CTRL_DTERM_BIT] ? term_s : ctrl_q[CTRL_STERM_BIT];

    // ************
    // delay counter and phase alignment
    // ************
    logic [TAP_W-1:0]            tap_q;
    logic [$clog2(LOCK_WORDS):0] train_q;

    // inputs act on the slow clock rising edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tap_q               <= TAP_ZERO;
            train_q             <= '0;
            align_lock          <= 1'b0;
            final_delay_setting <= TAP_ZERO;
        end else if (ce && rxp_rise) begin
            if (delay_adjust_reset_s) begin
                tap_q      <= TAP_ZERO;
                train_q    <= '0;
                align_lock <= 1'b0;
            end else if (dly_en_s && dly_mode == DLY_DYNAMIC) begin
                if (dly_up_s && tap_q != TAP_TOP) begin
                    tap_q <= tap_q + 1'b1;
                end else if (!dly_up_s && tap_q != TAP_ZERO) begin
                    tap_q <= tap_q - 1'b1;
                end
            end else if (dly_en_s && dly_mode == DLY_ALIGN && !align_lock) begin
                // training sweeps the tap; locks after a fixed word count
                if (train_q == ($clog2(LOCK_WORDS)+1)'(LOCK_WORDS - 1)) begin
                    align_lock          <= 1'b1;
                    final_delay_setting <= tap_q;
                end else begin
                    train_q <= train_q + 1'b1;
                    tap_q   <= tap_q + 1'b1;
                end
            end
        end
    end

    // ************
    // deserializer
    // ************
    logic [FACTOR_W-1:0]   rx_cnt_q;
    logic [MAX_WORD_W-1:0] rx_asm_q;
    logic [MAX_WORD_W-1:0] rx_hold_q;
    logic                  rx_hold_vld_q;
    logic                  rx_evt;
    logic                  pass_ok;
    logic                  push;
    logic [MAX_WORD_W-1:0] rx_next;

    // half rate captures on both fast edges, full rate on rise only
    assign rx_evt  = buf_on_s & (rxs_rise | (half_rate & rxs_fall));
    // training mode withholds words until lock
    assign pass_ok = (dly_mode != DLY_ALIGN) | align_lock;
    assign push    = rxp_rise & rx_hold_vld_q & pass_ok & fifo_on;

    always_comb begin
        rx_next           = rx_asm_q;
        rx_next[rx_cnt_q] = pad_bit_s;
    end

    // bit count restarts on reset; word held for the next slow edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_cnt_q      <= '0;
            rx_asm_q      <= '0;
            rx_hold_q     <= '0;
            rx_hold_vld_q <= 1'b0;
        end else if (ce) begin
            if (rx_rst_s) begin
                rx_cnt_q      <= '0;
                rx_asm_q      <= '0;
                rx_hold_vld_q <= 1'b0;
            end else begin
                if (rxp_rise) begin
                    rx_hold_vld_q <= 1'b0;
                end
                if (rx_evt) begin
                    if (rx_cnt_q == factor - FACTOR_ONE) begin
                        rx_hold_q     <= rx_next;
                        rx_hold_vld_q <= 1'b1;
                        rx_asm_q      <= '0;
                        rx_cnt_q      <= '0;
                    end else begin
                        rx_asm_q <= rx_next;
                        rx_cnt_q <= rx_cnt_q + FACTOR_ONE;
                    end
                end
            end
        end
    end

    // ************
    // read-side queue
    // ************
    logic [MAX_WORD_W-1:0] mem_q [FIFO_DEPTH];
    logic [PW:0]           wr_ptr_q;
    logic [PW:0]           rd_ptr_q;
    logic                  full;
    logic                  pop;

    assign xfer_queue_empty = (wr_ptr_q == rd_ptr_q);
    assign full             = (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]) && (wr_ptr_q[PW] != rd_ptr_q[PW]);
    // pops only on the read clock edge with strobe, never when empty
    assign pop              = fifo_on & rdc_rise & rd_s & ~xfer_queue_empty;

    // overflow drops the incoming word: the lane cannot stall the far transmitter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (ce) begin
            if (rx_rst_s) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
            end else begin
                if (push && !full) begin
                    mem_q[wr_ptr_q[PW-1:0]] <= rx_hold_q;
                    wr_ptr_q                <= wr_ptr_q + 1'b1;
                end
                if (pop) begin
                    rd_ptr_q <= rd_ptr_q + 1'b1;
                end
            end
        end
    end

    // ************
    // parallel output
    // ************
    // direct path on the slow rising edge, or from the queue on a pop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_word       <= '0;
            rx_word_valid <= 1'b0;
        end else if (ce) begin
            rx_word_valid <= 1'b0;
            if (rx_rst_s) begin
                rx_word <= '0;
            end else if (pop) begin
                rx_word       <= mem_q[rd_ptr_q[PW-1:0]];
                rx_word_valid <= 1'b1;
            end else if (!fifo_on && rxp_rise && rx_hold_vld_q && pass_ok) begin
                rx_word       <= rx_hold_q;
                rx_word_valid <= 1'b1;
            end
        end
    end

    // ************
    // serializer
    // ************
    logic [MAX_WORD_W-1:0] tx_shift_q;
    logic [MAX_WORD_W-1:0] tx_next_q;
    logic [FACTOR_W-1:0]   tx_cnt_q;
    logic                  tx_evt;

    assign tx_evt = txs_rise | (half_rate & txs_fall);

    // word taken on slow edge, shifted out lsb first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_shift_q <= '0;
            tx_next_q  <= '0;
            tx_cnt_q   <= '0;
            pad_p_o    <= 1'b0;
            pad_n_o    <= 1'b1;
        end else if (ce) begin
            if (tx_rst_s) begin
                tx_shift_q <= '0;
                tx_next_q  <= '0;
                tx_cnt_q   <= '0;
                pad_p_o    <= 1'b0;
                pad_n_o    <= 1'b1;
            end else begin
                if (txp_rise) begin
                    tx_next_q <= tx_word_s;
                end
                if (tx_evt) begin
                    if (tx_cnt_q == '0) begin
                        pad_p_o    <= tx_next_q[0];
                        pad_n_o    <= ~tx_next_q[0];
                        tx_shift_q <= tx_next_q >> 1;
                    end else begin
                        pad_p_o    <= tx_shift_q[0];
                        pad_n_o    <= ~tx_shift_q[0];
                        tx_shift_q <= tx_shift_q >> 1;
                    end
                    tx_cnt_q <= (tx_cnt_q == factor - FACTOR_ONE) ? '0 : tx_cnt_q + FACTOR_ONE;
                end
            end
        end
    end

    // turnaround: drivers release the pair when the enable drops
    assign pad_oe = oe_s;

    // ************
    // status word
    // ************
    always_comb begin
        stat_word                                 = '0;
        stat_word[STAT_LOCK_BIT]                  = align_lock;
        stat_word[STAT_EMPTY_BIT]                 = xfer_queue_empty;
        stat_word[STAT_FINAL_LSB +: TAP_W]        = final_delay_setting;
        stat_word[STAT_TAP_LSB +: TAP_W]          = tap_q;
    end

endmodule

// *** verif/lane_checker.sv ***
// checker for the serdes lane: bus wait, pads, resets, lock
// assumes one clk_sys domain and the top ports of serdes_lane
`timescale 1ns/1ps

module lane_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [3:0]  avs_address,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        output_enable,
    input wire logic        pad_oe,
    input wire logic        pad_p_o,
    input wire logic        pad_n_o,
    input wire logic        tx_path_reset,
    input wire logic        rx_path_reset,
    input wire logic        xfer_queue_empty,
    input wire logic        align_lock,
    input wire logic [5:0]  final_delay_setting
);
    // ************
    // properties
    // ************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // request still waiting
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // resets held past the synchroniser
    sequence s_txrst;
        tx_path_reset [*5];
    endsequence
    sequence s_rxrst;
        rx_path_reset [*5];
    endsequence
    a_bus_wait: assert property (s_req |=> !avs_waitrequest) else $error("bus wait too long");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address != 4'h0
        && avs_address != 4'h4 |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_oe_drive: assert property ($rose(output_enable) |-> ##[1:5] pad_oe)
        else $error("pad enable late");
    a_txrst_idle: assert property (s_txrst |-> !pad_p_o && pad_n_o)
        else $error("pads not idle in tx reset");
    a_rxrst_empty: assert property (s_rxrst |-> xfer_queue_empty)
        else $error("queue not cleared");
    a_pad_pair: assert property (pad_n_o == !pad_p_o)
        else $error("pad pair not complementary");
    a_reset_idle: assert property ($fell(rst) |-> !pad_oe && !align_lock && xfer_queue_empty)
        else $error("bad state after reset");
    a_lock_hold: assert property (align_lock && $past(align_lock) |-> $stable(final_delay_setting))
        else $error("final tap moved while locked");
endmodule

bind serdes_lane lane_checker u_chk (.clk_sys, .rst, .avs_read, .avs_write, .avs_address,
    .avs_readdata, .avs_waitrequest, .output_enable, .pad_oe, .pad_p_o, .pad_n_o,
    .tx_path_reset, .rx_path_reset, .xfer_queue_empty, .align_lock, .final_delay_setting);

// *** verif/pad_partner.sv ***
// far-side partner: sends one 4-bit word forever, collects sent bits
// assumes factor 4 full rate, serial clocks park low when stopped
`timescale 1ns/1ps

module pad_partner (
    input  wire logic       rx_clk,
    input  wire logic       tx_clk,
    input  wire logic [3:0] word,
    input  wire logic       pad_p_o,
    output logic            pad_p_i,
    output logic            pad_n_i,
    output logic [3:0]      got
);
    // ************
    // link model
    // ************
    int unsigned rx_n = 0;
    int unsigned tx_n = 0;
    logic [3:0]  sh   = 4'h0;
    initial got = 4'h0;
    // bit moves on the fall so it is settled at the rise
    always @(negedge rx_clk) rx_n <= rx_n + 1;
    assign pad_p_i = word[rx_n % 4];
    assign pad_n_i = !pad_p_i;
    // pads lag the edge by the sync delay, so take the previous bit
    always @(posedge tx_clk) begin
        if (tx_n != 0) sh = {pad_p_o, sh[3:1]};
        if (tx_n != 0 && tx_n % 4 == 0) got <= sh;
        tx_n <= tx_n + 1;
    end
endmodule

// *** verif/serdes_lane_tb.sv ***
// bench for the serdes lane: registers, both link directions, queue, delay
// assumes lane_pkg, serdes_lane, pad_partner and the bound checker
`timescale 1ns/1ps

module serdes_lane_tb;
    import lane_pkg::*;
    // ************
    // signals and clocks
    // ************
    logic        clk_sys = 0, rst = 1, run = 0, sclk = 0, pclk = 0, qclk = 0;
    logic        avs_read = 0, avs_write = 0, rx_path_reset = 0, tx_path_reset = 0;
    logic        output_enable = 0, xfer_queue_read = 0, termination_ctrl = 0;
    logic        delay_adjust_enable = 0, delay_step_up = 0, delay_adjust_reset = 0;
    logic [3:0]  avs_address = 4'h0, got;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [9:0]  tx_word = 10'h003, rx_word;
    logic [5:0]  final_delay_setting;
    logic        avs_waitrequest, xfer_queue_empty, rx_word_valid, termination_on, align_lock;
    logic        pad_p_i, pad_n_i, pad_p_o, pad_n_o, pad_oe;
    int          error_cnt = 0, checks = 0, cyc = 0, vcnt = 0, v0 = 0, div = 0;
    always #12.5 clk_sys = !clk_sys;
    // 200 ns link clocks, offset from clk_sys edges
    initial #7 forever #100 begin
        qclk = !qclk;
        if (run || sclk) sclk = !sclk;
    end
    // slow clock is the serial rate over four
    always @(negedge sclk) begin
        div <= div + 1;
        if (div % 2 == 1) pclk <= !pclk;
    end
    // hang guard and delivered word count
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rx_word_valid) vcnt <= vcnt + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    serdes_lane #(.LOCK_WORDS(2)) uut (.clk_sys, .rst, .ce(1'b1), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
        .rx_parallel_clock(pclk), .rx_serial_clock(sclk), .tx_parallel_clock(pclk),
        .tx_serial_clock(sclk), .xfer_queue_read_clock(qclk), .rx_path_reset,
        .input_buffer_on(1'b1), .termination_ctrl, .xfer_queue_read, .xfer_queue_empty, .rx_word,
        .rx_word_valid, .termination_on, .delay_adjust_enable, .delay_step_up, .delay_adjust_reset,
        .align_lock, .final_delay_setting, .tx_word, .tx_path_reset, .output_enable, .pad_p_i,
        .pad_n_i, .pad_p_o, .pad_n_o, .pad_oe);
    pad_partner far (.rx_clk(sclk), .tx_clk(sclk), .word(4'hb), .pad_p_o, .pad_p_i, .pad_n_i, .got);
    // ************
    // tasks
    // ************
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // request held until waitrequest is seen low at a rise; data taken there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wvalid();
        int t;
        @(negedge clk_sys);
        for (t = 0; t < 400 && rx_word_valid !== 1'b1; t++) @(negedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ************
    // sequence
    // ************
    initial begin
        tick(6);
        rst <= 0;
        bus(0, CTRL_OFFS, 0);
        cmp(q, 32'h018);
        bus(0, STAT_OFFS, 0);
        cmp(q, 32'h2);
        bus(0, 4'h8, 0);
        cmp(q, 0);
        bus(1, CTRL_OFFS, 32'h004);
        output_enable <= 1;
        run <= 1;
        wvalid();
        wvalid();
        cmp(rx_word[3:0], 4'hb);
        tick(300);
        cmp(got, 4'h3);
        tx_path_reset <= 1;
        tick(8);
        cmp(pad_n_o, 1'b1);
        tx_path_reset <= 0;
        bus(1, CTRL_OFFS, 32'h104);
        for (int v = 0; v < 2; v++) begin
            termination_ctrl <= v[0];
            tick(6);
            cmp(termination_on, v[0]);
        end
        bus(1, CTRL_OFFS, 32'h044);
        delay_adjust_enable <= 1;
        for (int u = 1; u >= 0; u--) begin
            delay_step_up <= u[0];
            tick(2400);
            bus(0, STAT_OFFS, 0);
            cmp(q[21:16], u ? TAP_TOP : TAP_ZERO);
        end
        delay_step_up <= 1;
        tick(200);
        delay_adjust_reset <= 1;
        tick(100);
        bus(0, STAT_OFFS, 0);
        cmp(q[21:16], TAP_ZERO);
        delay_adjust_enable <= 0;
        bus(1, CTRL_OFFS, 32'h084);
        delay_adjust_reset <= 0;
        v0 = vcnt;
        tick(300);
        cmp(vcnt - v0, 0);
        delay_adjust_enable <= 1;
        tick(300);
        cmp(align_lock, 1'b1);
        wvalid();
        cmp(rx_word[3:0], 4'hb);
        delay_adjust_reset <= 1;
        tick(100);
        cmp(align_lock, 1'b0);
        delay_adjust_reset <= 0;
        delay_adjust_enable <= 0;
        bus(1, CTRL_OFFS, 32'h024);
        tick(600);
        cmp(xfer_queue_empty, 1'b0);
        run <= 0;
        tick(40);
        v0 = vcnt;
        xfer_queue_read <= 1;
        tick(100);
        cmp(vcnt - v0, FIFO_DEPTH_DEF);
        cmp(xfer_queue_empty, 1'b1);
        cmp(rx_word[3:0], 4'hb);
        tick(100);
        cmp(vcnt - v0, FIFO_DEPTH_DEF);
        xfer_queue_read <= 0;
        run <= 1;
        tick(300);
        cmp(xfer_queue_empty, 1'b0);
        run <= 0;
        rx_path_reset <= 1;
        tick(8);
        cmp(xfer_queue_empty, 1'b1);
        rx_path_reset <= 0;
        wrap_up();
    end
endmodule
